// File: design/sts_status_regs.sv
`timescale 1ns/1ps
`include "sts_regs.svh"

module sts_status_regs
  import sts_pkg::*;
#(
  parameter int unsigned NUM_OSC = 4
) (
  input  wire logic               clock,
  input  wire logic               rst_b,
  input  wire sts_reg_req_t       reg_req,
  output sts_reg_rsp_t            reg_rsp_q,
  input  wire logic               fast_accum_reset_wr,
  input  wire logic [3:0]         fast_accum_reset_field,
  input  wire logic [7:0]         temp_code_async,
  input  wire logic               sysref_detect_evt,
  input  wire logic               divider_realign_evt,
  input  wire logic               divider_phase_match,
  input  wire logic [NUM_OSC-1:0] osc_sync_evt,
  output logic                    sensor_sleep_bit_q
);

  logic [3:0] accum_reset_readback_q;
  logic [7:0] temp_meta_q;
  logic [7:0] temperature_reading_q;
  logic [7:0] sleep_reg_q;
  logic       divider_aligned_indicator_q;
  logic       sysref_seen_flag;
  logic       realigned_flag;
  logic       oscillator_sync_flag;
  logic       sync_wr;
  logic [7:0] rd_data_d;

  function automatic logic hit(input sts_reg_req_t req, input logic [`STS_ADDR_W-1:0] ofs);
    hit = (req.addr == ofs);
  endfunction : hit

  assign sync_wr = reg_req.wr && hit(reg_req, `STS_OFS_SYNC);

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      accum_reset_readback_q <= `STS_AR_RST;
    end else if (fast_accum_reset_wr) begin
      accum_reset_readback_q <= fast_accum_reset_field;
    end
  end

  // sensor code comes from the analog converter, so it is resynchronised;
  // a code changing mid-capture can tear, which slower host reads make harmless
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      temp_meta_q           <= `STS_TEMP_RST;
      temperature_reading_q <= `STS_TEMP_RST;
    end else begin
      temp_meta_q           <= temp_code_async;
      temperature_reading_q <= temp_meta_q;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      sleep_reg_q        <= `STS_SLEEP_RST;
      sensor_sleep_bit_q <= `STS_SLEEP_BIT_RST;
    end else if (reg_req.wr && hit(reg_req, `STS_OFS_SLEEP)) begin
      sleep_reg_q        <= reg_req.wdata;
      sensor_sleep_bit_q <= reg_req.wdata[`STS_SLEEP_BIT];
    end
  end

  // live phase match, no write path
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      divider_aligned_indicator_q <= `STS_FLAG_RST;
    end else begin
      divider_aligned_indicator_q <= divider_phase_match;
    end
  end

  sts_sticky_flag u_sysref_flag (
    .clock   (clock),
    .rst_b   (rst_b),
    .set_evt (sysref_detect_evt),
    .clr_wr  (sync_wr && reg_req.wdata[`STS_SYNC_SYSREF]),
    .flag_q  (sysref_seen_flag)
  );

  sts_sticky_flag u_realign_flag (
    .clock   (clock),
    .rst_b   (rst_b),
    .set_evt (divider_realign_evt),
    .clr_wr  (sync_wr && reg_req.wdata[`STS_SYNC_REALIGN]),
    .flag_q  (realigned_flag)
  );

  sts_sticky_flag u_osc_flag (
    .clock   (clock),
    .rst_b   (rst_b),
    .set_evt (|osc_sync_evt),
    .clr_wr  (sync_wr && reg_req.wdata[`STS_SYNC_OSC]),
    .flag_q  (oscillator_sync_flag)
  );

  always_comb begin
    rd_data_d = `STS_READ_ZERO;
    case (reg_req.addr)
      `STS_OFS_AR_READBACK: rd_data_d = {4'h0, accum_reset_readback_q};
      `STS_OFS_TEMP: rd_data_d = sleep_reg_q[`STS_SLEEP_BIT] ? `STS_READ_ZERO
                                                              : temperature_reading_q;
      `STS_OFS_SLEEP: rd_data_d = sleep_reg_q;
      `STS_OFS_SYNC: begin
        rd_data_d[`STS_SYNC_REALIGN] = realigned_flag;
        rd_data_d[`STS_SYNC_ALIGNED] = divider_aligned_indicator_q;
        rd_data_d[`STS_SYNC_OSC]     = oscillator_sync_flag;
        rd_data_d[`STS_SYNC_SYSREF]  = sysref_seen_flag;
      end
      default: rd_data_d = `STS_READ_ZERO;
    endcase
  end

  // answer one cycle after the read strobe; data holds until the next read
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      reg_rsp_q <= '0;
    end else begin
      reg_rsp_q.valid <= reg_req.rd;
      if (reg_req.rd) begin
        reg_rsp_q.data <= rd_data_d;
      end
    end
  end

  property p_ar_read;
    @(posedge clock) disable iff (!rst_b)
      (reg_req.rd && reg_req.addr == `STS_OFS_AR_READBACK)
        |=> reg_rsp_q.valid && reg_rsp_q.data == {4'h0, $past(accum_reset_readback_q)};
  endproperty
  a_ar_read: assert property (p_ar_read) else $error("ar readback mismatch");

  property p_ar_capture;
    @(posedge clock) disable iff (!rst_b)
      fast_accum_reset_wr ##1 (!fast_accum_reset_wr && reg_req.rd
                               && reg_req.addr == `STS_OFS_AR_READBACK)
        |=> reg_rsp_q.data[3:0] == $past(fast_accum_reset_field, 2);
  endproperty
  a_ar_capture: assert property (p_ar_capture) else $error("ar value not captured");

  property p_temp_read;
    @(posedge clock) disable iff (!rst_b)
      (reg_req.rd && reg_req.addr == `STS_OFS_TEMP && !sleep_reg_q[0])
        |=> reg_rsp_q.data == $past(temperature_reading_q);
  endproperty
  a_temp_read: assert property (p_temp_read) else $error("temperature read mismatch");

  property p_temp_sleep;
    @(posedge clock) disable iff (!rst_b)
      (reg_req.rd && reg_req.addr == `STS_OFS_TEMP && sensor_sleep_bit_q)
        |=> reg_rsp_q.data == 8'h00;
  endproperty
  a_temp_sleep: assert property (p_temp_sleep) else $error("sleeping sensor gave data");

  property p_sleep_wr;
    @(posedge clock) disable iff (!rst_b)
      (reg_req.wr && reg_req.addr == `STS_OFS_SLEEP)
        |=> sleep_reg_q == $past(reg_req.wdata)
            && sensor_sleep_bit_q == $past(reg_req.wdata[0]);
  endproperty
  a_sleep_wr: assert property (p_sleep_wr) else $error("sleep write not stored");

  property p_realign_set;
    @(posedge clock) disable iff (!rst_b)
      divider_realign_evt |=> realigned_flag;
  endproperty
  a_realign_set: assert property (p_realign_set) else $error("realign flag not set");

  property p_aligned_live;
    @(posedge clock) disable iff (!rst_b)
      (reg_req.rd && reg_req.addr == `STS_OFS_SYNC)
        |=> reg_rsp_q.data[2] == $past(divider_phase_match, 2);
  endproperty
  a_aligned_live: assert property (p_aligned_live) else $error("aligned bit not live");

  property p_aligned_nowr;
    @(posedge clock) disable iff (!rst_b)
      sync_wr ##1 1'b1 |-> divider_aligned_indicator_q == $past(divider_phase_match);
  endproperty
  a_aligned_nowr: assert property (p_aligned_nowr) else $error("write altered aligned");

  property p_osc_set;
    @(posedge clock) disable iff (!rst_b)
      (|osc_sync_evt) |=> oscillator_sync_flag;
  endproperty
  a_osc_set: assert property (p_osc_set) else $error("osc sync flag not set");

  property p_sysref_clear;
    @(posedge clock) disable iff (!rst_b)
      (sync_wr && reg_req.wdata[0] && !sysref_detect_evt) |=> !sysref_seen_flag;
  endproperty
  a_sysref_clear: assert property (p_sysref_clear) else $error("sysref flag not cleared");

  property p_set_wins;
    @(posedge clock) disable iff (!rst_b)
      (sync_wr && reg_req.wdata[0] && sysref_detect_evt) |=> sysref_seen_flag [*1];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat a set event");

  property p_zero_keeps;
    @(posedge clock) disable iff (!rst_b)
      (sync_wr && reg_req.wdata[3] == 1'b0 && realigned_flag) |=> realigned_flag;
  endproperty
  a_zero_keeps: assert property (p_zero_keeps) else $error("zero write cleared flag");

endmodule : sts_status_regs

// File: design/sts_regs.svh
`ifndef STS_REGS_SVH
`define STS_REGS_SVH

// register offsets as seen from the serial register port
`define STS_ADDR_W          12
`define STS_OFS_AR_READBACK 12'h3e1
`define STS_OFS_TEMP        12'h400
`define STS_OFS_SLEEP       12'h401
`define STS_OFS_SYNC        12'h410

// field positions
`define STS_AR_MSB          3
`define STS_SLEEP_BIT       0
`define STS_SYNC_REALIGN    3
`define STS_SYNC_ALIGNED    2
`define STS_SYNC_OSC        1
`define STS_SYNC_SYSREF     0

// reset values
`define STS_SLEEP_RST       8'h00
`define STS_SLEEP_BIT_RST   1'b0
`define STS_AR_RST          4'h0
`define STS_TEMP_RST        8'h00
`define STS_FLAG_RST        1'b0

// value returned for unmapped offsets and for a sleeping sensor
`define STS_READ_ZERO       8'h00

`endif

// File: design/sts_pkg.sv
`include "sts_regs.svh"

package sts_pkg;

  typedef struct packed {
    logic                     rd;
    logic                     wr;
    logic [`STS_ADDR_W-1:0]   addr;
    logic [7:0]               wdata;
  } sts_reg_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } sts_reg_rsp_t;

  typedef struct packed {
    logic sysref_seen;
    logic realigned;
    logic aligned;
    logic osc_sync;
  } sts_sync_evt_t;

endpackage : sts_pkg

// File: design/sts_sticky_flag.sv
`timescale 1ns/1ps
`include "sts_regs.svh"

module sts_sticky_flag (
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic set_evt,
  input  wire logic clr_wr,
  output logic      flag_q
);

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      flag_q <= `STS_FLAG_RST;
    end else if (set_evt) begin
      // set beats clear
      // set wins so an event landing on the clearing write survives
      flag_q <= 1'b1;
    end else if (clr_wr) begin
      flag_q <= 1'b0;
    end
  end

endmodule : sts_sticky_flag

// File: testbench/sts_host_model.sv
`timescale 1ns/1ps
`include "sts_regs.svh"

module sts_host_model
  import sts_pkg::*;
(
  input  wire logic         clock,
  input  wire logic         fast_busy,
  output sts_reg_req_t      reg_req,
  input  wire sts_reg_rsp_t reg_rsp_q
);
  initial reg_req = '0;

  // released lines flip so a stale value never passes for a live one
  task automatic idle();
    reg_req.rd    = 1'b0;
    reg_req.wr    = 1'b0;
    reg_req.addr  = ~reg_req.addr;
    reg_req.wdata = ~reg_req.wdata;
  endtask : idle

  // callers enter just after a rising edge
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    reg_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clock);
    #1;
    idle();
    // one quiet edge so a following call never re-raises a strobe just lowered
    @(posedge clock);
    #1;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [7:0] d, output logic v);
    repeat ((a == `STS_OFS_TEMP) ? 4 : 0) begin
      @(posedge clock);
      #1;
    end
    while (a == `STS_OFS_AR_READBACK && fast_busy) begin
      @(posedge clock);
      #1;
    end
    reg_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge clock);
    #1;
    d = reg_rsp_q.data;
    v = reg_rsp_q.valid;
    idle();
    @(posedge clock);
    #1;
  endtask : rd

  function automatic int celsius(input logic [7:0] c);
    return int'(c) - 80;
  endfunction : celsius
endmodule : sts_host_model

// File: testbench/sts_status_regs_tb.sv
`timescale 1ns/1ps

module sts_status_regs_tb
  import sts_pkg::*;
;
  logic         clock = 1'b0;
  logic         rst_b = 1'b0;
  sts_reg_req_t reg_req;
  sts_reg_rsp_t reg_rsp_q;
  logic         far_wr = 1'b0;
  logic [3:0]   far_field = 4'h0;
  logic [7:0]   temp_code = 8'h00;
  logic         sysref_evt = 1'b0;
  logic         realign_evt = 1'b0;
  logic         phase_match = 1'b0;
  logic [3:0]   osc_evt = 4'h0;
  logic         sleep_q;
  logic [7:0]   d;
  logic [7:0]   e;
  logic         v;
  int           n_fail = 0;
  int           checks_done = 0;
  int           cycles = 0;

  always #20 clock = ~clock;

  sts_status_regs dut (
    .clock(clock), .rst_b(rst_b), .reg_req(reg_req), .reg_rsp_q(reg_rsp_q),
    .fast_accum_reset_wr(far_wr), .fast_accum_reset_field(far_field),
    .temp_code_async(temp_code), .sysref_detect_evt(sysref_evt),
    .divider_realign_evt(realign_evt), .divider_phase_match(phase_match),
    .osc_sync_evt(osc_evt), .sensor_sleep_bit_q(sleep_q)
  );

  sts_host_model host (
    .clock(clock), .fast_busy(far_wr), .reg_req(reg_req), .reg_rsp_q(reg_rsp_q)
  );

  task automatic end_sim();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim

  // a full run takes far less than this ceiling
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      end_sim();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic step();
    @(posedge clock);
    #1;
  endtask : step

  task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
    host.rd(a, d, v);
    chk({7'h00, v}, 8'h01);
    chk(d, exp);
  endtask : rdc

  task automatic t_readback();
    far_field = 4'ha;
    far_wr = 1'b1;
    step();
    far_wr = 1'b0;
    rdc(12'h3e1, 8'h0a);
    host.wr(12'h3e1, 8'hff);
    rdc(12'h3e1, 8'h0a);
    far_field = 4'hf;
    far_wr = 1'b1;
    step();
    far_wr = 1'b0;
    rdc(12'h3e1, 8'h0f);
  endtask : t_readback

  task automatic t_temp();
    temp_code = 8'd110;
    repeat (3) step();
    rdc(12'h400, 8'd110);
    chk(8'(host.celsius(d)), 8'd30);
    temp_code = 8'hff;
    host.wr(12'h401, 8'hff);
    chk({7'h00, sleep_q}, 8'h01);
    rdc(12'h401, 8'hff);
    rdc(12'h400, 8'h00);
    host.wr(12'h401, 8'h00);
    repeat (3) step();
    rdc(12'h400, 8'hff);
  endtask : t_temp

  task automatic t_sticky();
    for (int k = 0; k < 6; k++) begin
      e = (k == 0) ? 8'h01 : (k == 5) ? 8'h08 : 8'h02;
      sysref_evt = (k == 0);
      realign_evt = (k == 5);
      osc_evt = (k > 0 && k < 5) ? 4'h1 << (k - 1) : 4'h0;
      step();
      sysref_evt = 1'b0;
      realign_evt = 1'b0;
      osc_evt = 4'h0;
      rdc(12'h410, e);
      host.wr(12'h410, 8'h00);
      rdc(12'h410, e);
      host.wr(12'h410, e);
      rdc(12'h410, 8'h00);
    end
    // set and clear on one edge only; the write's quiet edge must not clear it
    fork
      host.wr(12'h410, 8'h01);
      begin
        sysref_evt = 1'b1;
        step();
        sysref_evt = 1'b0;
      end
    join
    rdc(12'h410, 8'h01);
    host.wr(12'h410, 8'h01);
    rdc(12'h410, 8'h00);
  endtask : t_sticky

  task automatic t_aligned();
    phase_match = 1'b1;
    repeat (2) step();
    rdc(12'h410, 8'h04);
    host.wr(12'h410, 8'hff);
    rdc(12'h410, 8'h04);
    phase_match = 1'b0;
    repeat (2) step();
    rdc(12'h410, 8'h00);
  endtask : t_aligned

  initial begin
    repeat (10) @(posedge clock);
    #1;
    rst_b = 1'b1;
    step();
    chk({7'h00, sleep_q}, 8'h00);
    rdc(12'h401, 8'h00);
    rdc(12'h410, 8'h00);
    rdc(12'h123, 8'h00);
    t_readback();
    t_temp();
    t_sticky();
    t_aligned();
    end_sim();
  end
endmodule : sts_status_regs_tb
